// ---- dv/pfr_fault_src.sv ----
/*
 Model of the translation pipeline that reports faults to the recorder.
 Assumes it shares the recorder's clock; the bench calls its tasks.
*/
`timescale 1ns/1ps
module pfr_fault_src (
   input  wire logic             aclk,
   output logic                  address_xlat_on,
   output logic                  intr_remap_on,
   output logic                  interrupt_xlat_on,
   output logic                  fault_valid,
   output pfr_pkg::pfr_info_type fault_info
);
   initial begin
      address_xlat_on = 1'b0;
      intr_remap_on = 1'b0;
      interrupt_xlat_on = 1'b0;
      fault_valid = 1'b0;
      fault_info = '0;
   end

   // Only the enables move; the logging method is never switched
   task automatic set_xlat(input logic a, input logic i);
      @(posedge aclk);
      address_xlat_on <= a;
      intr_remap_on <= a;
      interrupt_xlat_on <= i;
   endtask

   // One-cycle report; the recorder has no ready to wait for
   task automatic send(input logic [15:0] tag);
      @(posedge aclk);
      fault_valid <= 1'b1;
      fault_info <= '{tag: tag, reason: tag[7:0] ^ 8'h3C, addr: {16'hA5A5, tag}};
      @(posedge aclk);
      fault_valid <= 1'b0;
      // Scrambled after the pulse so a late sample cannot look right
      fault_info <= ~fault_info;
   endtask
endmodule

// ---- dv/testbench.sv ----
/*
 Self-checking bench of the fault recorder: reset view, storing, duplicates,
 wrap and overflow, event masking, index reset.
 Assumes pfr_top and the pfr_fault_src model on one 10 MHz clock.
*/
`timescale 1ns/1ps
`include "pfr_map.svh"
module testbench;
   logic                  aclk, aresetn, address_xlat_on, intr_remap_on, interrupt_xlat_on;
   logic                  fault_valid, fault_event, irq, ce;
   pfr_pkg::pfr_info_type fault_info;
   logic [11:0]           awaddr, araddr;
   logic [31:0]           wdata, rdata, d;
   logic [3:0]            wstrb;
   logic [1:0]            bresp, rresp, r;
   logic                  awvalid, awready, wvalid, wready, bvalid, bready;
   logic                  arvalid, arready, rvalid, rready;
   int                    failures, cmp_count, ev_count;

   pfr_top pfr_top_inst (
      .aclk(aclk), .aresetn(aresetn), .ce(ce), .address_xlat_on(address_xlat_on),
      .intr_remap_on(intr_remap_on), .interrupt_xlat_on(interrupt_xlat_on),
      .fault_valid(fault_valid), .fault_info(fault_info), .fault_event(fault_event),
      .irq(irq), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
   );
   pfr_fault_src pfr_fault_src_inst (
      .aclk(aclk), .address_xlat_on(address_xlat_on), .intr_remap_on(intr_remap_on),
      .interrupt_xlat_on(interrupt_xlat_on), .fault_valid(fault_valid),
      .fault_info(fault_info)
   );

   always #50 aclk = ~aclk;

   always @(posedge aclk) begin
      if (fault_event === 1'b1) begin
         ev_count <= ev_count + 1;
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic aw_ok;
      logic w_ok;
      @(posedge aclk);
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= v;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic rc(input logic [11:0] a, input logic [31:0] exp, input string what);
      rd(a);
      chk(what, exp, d);
   endtask

   function automatic logic [31:0] sts(input logic p, input logic o, input logic [2:0] f);
      return {21'h0, f, 6'h0, o, p};
   endfunction

   task automatic slot_chk(input int k, input logic [15:0] tag, input logic v);
      logic [11:0] b;
      b = 12'h100 + 12'(k * 16);
      if (v) begin
         rc(b, {16'hA5A5, tag}, "slot address");
         rc(b + 12'h004, {8'h00, tag[7:0] ^ 8'h3C, tag}, "slot info");
      end
      rc(b + 12'h008, {31'h0, v}, "slot valid");
   endtask

   // Software drain: every slot cleared, circularly from the first-pending one
   task automatic clear_all(input int first);
      for (int k = 0; k < `PFR_NSLOT; k++) begin
         wr(12'h108 + 12'(((first + k) % `PFR_NSLOT) * 16), 32'h0000_0001);
      end
   endtask

   task automatic sc_reset_view;
      rc(`PFR_OFF_CAP, 32'h0000_0108, "capability");
      rc(`PFR_OFF_STS, 32'h0000_0000, "status");
      rc(`PFR_OFF_EVC, 32'h0000_0001, "event control");
      rc(`PFR_OFF_CTL, 32'h0000_0001, "control");
      wr(`PFR_OFF_CAP, 32'h0000_0000);
      chk("write resp", 32'h0000_0000, {30'h0, r});
      rc(`PFR_OFF_CAP, 32'h0000_0108, "capability kept");
      rd(12'h01C);
      chk("unmapped resp", 32'h0000_0002, {30'h0, r});
      chk("unmapped data", 32'h0000_0000, d);
      wr(12'h01C, 32'h0000_0001);
      chk("unmapped wresp", 32'h0000_0002, {30'h0, r});
   endtask

   task automatic sc_first_store;
      int ev;
      pfr_fault_src_inst.set_xlat(1'b1, 1'b1);
      wr(`PFR_OFF_EVC, 32'h0000_0000);
      wr(`PFR_OFF_IEN, 32'h0000_0007);
      ev = ev_count;
      pfr_fault_src_inst.send(16'h0011);
      rc(`PFR_OFF_STS, sts(1'b1, 1'b0, 3'd0), "status first");
      chk("fault event", 32'(ev + 1), 32'(ev_count));
      chk("irq stored", 32'h0000_0001, {31'h0, irq});
      slot_chk(0, 16'h0011, 1'b1);
      pfr_fault_src_inst.send(16'h0022);
      slot_chk(1, 16'h0022, 1'b1);
      rc(`PFR_OFF_STS, sts(1'b1, 1'b0, 3'd0), "status second");
      chk("fault event", 32'(ev + 1), 32'(ev_count));
      wr(`PFR_OFF_IEN, 32'h0000_0000);
      chk("irq disabled", 32'h0000_0000, {31'h0, irq});
      wr(`PFR_OFF_IEN, 32'h0000_0007);
      wr(`PFR_OFF_ICLR, 32'h0000_0007);
      chk("irq cleared", 32'h0000_0000, {31'h0, irq});
   endtask

   task automatic sc_duplicate;
      pfr_fault_src_inst.send(16'h0011);
      slot_chk(2, 16'h0011, 1'b0);
      rc(`PFR_OFF_IST, 32'h0000_0004, "drop status");
      wr(`PFR_OFF_CTL, 32'h0000_0000);
      pfr_fault_src_inst.send(16'h0011);
      slot_chk(2, 16'h0011, 1'b1);
   endtask

   task automatic sc_wrap_overflow;
      int ev;
      for (int k = 3; k < 8; k++) begin
         pfr_fault_src_inst.send(16'h0030 + 16'(k));
      end
      slot_chk(7, 16'h0037, 1'b1);
      wr(12'h108, 32'h0000_0001);
      pfr_fault_src_inst.send(16'h0040);
      slot_chk(0, 16'h0040, 1'b1);
      pfr_fault_src_inst.send(16'h0041);
      rc(`PFR_OFF_STS, sts(1'b1, 1'b1, 3'd0), "overflow");
      slot_chk(1, 16'h0022, 1'b1);
      wr(12'h118, 32'h0000_0001);
      pfr_fault_src_inst.send(16'h0042);
      slot_chk(1, 16'h0042, 1'b0);
      clear_all(0);
      rc(`PFR_OFF_STS, sts(1'b0, 1'b1, 3'd0), "drained");
      wr(`PFR_OFF_STS, 32'h0000_0002);
      ev = ev_count;
      pfr_fault_src_inst.send(16'h0050);
      rc(`PFR_OFF_STS, sts(1'b1, 1'b0, 3'd1), "resumed");
      chk("fault event", 32'(ev + 1), 32'(ev_count));
      slot_chk(1, 16'h0050, 1'b1);
   endtask

   task automatic sc_event_mask;
      int ev;
      clear_all(1);
      wr(`PFR_OFF_EVC, 32'h0000_0001);
      ev = ev_count;
      pfr_fault_src_inst.send(16'h0060);
      rc(`PFR_OFF_EVC, 32'h0000_0003, "held event");
      chk("fault event", 32'(ev), 32'(ev_count));
      wr(`PFR_OFF_EVC, 32'h0000_0000);
      rc(`PFR_OFF_EVC, 32'h0000_0000, "released event");
      chk("fault event", 32'(ev + 1), 32'(ev_count));
   endtask

   task automatic sc_index_zero;
      clear_all(2);
      pfr_fault_src_inst.set_xlat(1'b0, 1'b1);
      pfr_fault_src_inst.send(16'h0070);
      rc(`PFR_OFF_STS, sts(1'b1, 1'b0, 3'd3), "index kept");
      clear_all(3);
      pfr_fault_src_inst.set_xlat(1'b0, 1'b0);
      pfr_fault_src_inst.set_xlat(1'b1, 1'b0);
      pfr_fault_src_inst.send(16'h0071);
      rc(`PFR_OFF_STS, sts(1'b1, 1'b0, 3'd0), "index forced");
   endtask

   // Frozen clock enable must drop a fault and refuse the bus; a write without
   // its low strobe byte must leave the register alone
   task automatic sc_freeze;
      @(posedge aclk);
      ce <= 1'b0;
      pfr_fault_src_inst.send(16'h0080);
      chk("frozen ready", 32'h0000_0000, {29'h0, awready, wready, arready});
      @(posedge aclk);
      ce <= 1'b1;
      slot_chk(1, 16'h0080, 1'b0);
      rc(`PFR_OFF_STS, sts(1'b1, 1'b0, 3'd0), "frozen status");
      wstrb <= 4'h0;
      wr(`PFR_OFF_EVC, 32'h0000_0001);
      wstrb <= 4'hF;
      rc(`PFR_OFF_EVC, 32'h0000_0000, "strobe off");
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Whole run needs a few hundred cycles; this leaves ample margin
   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      close_out;
   end

   initial begin
      aclk = 1'b0;
      ce = 1'b1;
      aresetn = 1'b0;
      awaddr = '0;
      awvalid = 1'b0;
      wdata = '0;
      wstrb = 4'hF;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = '0;
      arvalid = 1'b0;
      rready = 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      sc_reset_view;
      sc_first_store;
      sc_duplicate;
      sc_wrap_overflow;
      sc_event_mask;
      sc_index_zero;
      sc_freeze;
      close_out;
   end
endmodule

// ---- shared/pfr_map.svh ----
/*
 Offsets, field positions, reset values and sizes of the primary fault recorder.
 Assumes a 32-bit AXI4-Lite register port with 12 significant address bits.
*/
// Behaviour
// - Slot-based fault logging is always built; no memory log exists.
// - A read-only capability field reports the number of fault slots.
// - Write index is held at zero while both translations are off.
// - Each stored fault advances the index by one, wrapping to zero.
// - Pending flag is the OR of all slot valid bits, always current.
// - With overflow already set, new faults are dropped untouched.
// - When enabled, a fault whose tag matches a valid slot is dropped.
// - Duplicate suppression is provided, as advised for few slots.
// - Fault landing on a valid slot sets overflow and is dropped.
// - Otherwise store at index, set valid, advance index.
// - First store with nothing pending records the index and requests an event.
// - After overflow clears, storing resumes at the current index.
// - Event suppressed if a status flag is set; else hold, send if unmasked.
`ifndef PFR_MAP_SVH
`define PFR_MAP_SVH
`define PFR_NSLOT      8
`define PFR_IDXW       3
`define PFR_OFF_CAP    12'h000
`define PFR_OFF_STS    12'h004
`define PFR_OFF_EVC    12'h008
`define PFR_OFF_CTL    12'h00C
`define PFR_OFF_IST    12'h010
`define PFR_OFF_ICLR   12'h014
`define PFR_OFF_IEN    12'h018
`define PFR_OFF_SLOT   12'h100
`define PFR_SLOT_SPAN  12'h080
`define PFR_SLW_ADDR   2'h0
`define PFR_SLW_INFO   2'h1
`define PFR_SLW_VALID  2'h2
`define PFR_CAP_DUP    8
`define PFR_STS_PEND   0
`define PFR_STS_OVF    1
`define PFR_STS_FPI    8
`define PFR_EVC_MASK   0
`define PFR_EVC_HOLD   1
`define PFR_CTL_DUP    0
`define PFR_CTL_RST    1'b1
`define PFR_MASK_RST   1'b1
`define PFR_IRQW       3
`define PFR_IRQ_STORE  0
`define PFR_IRQ_OVF    1
`define PFR_IRQ_DROP   2
`endif

// ---- shared/pfr_pkg.sv ----
/*
 Types of the primary fault recorder.
 Assumes the requester tag is 16 bits and the reason code 8 bits.
*/
package pfr_pkg;
   typedef struct packed {
      logic [15:0] tag;
      logic [7:0]  reason;
      logic [31:0] addr;
   } pfr_info_type;
endpackage

// ---- src/pfr_top.sv ----
/*
 Primary fault recorder: circular fault slots, overflow, first-pending index,
 duplicate suppression, fault event gating and an AXI4-Lite register slave.
 Assumes fault reports and global status levels come from logic on aclk.
*/
`timescale 1ns/1ps
`include "pfr_map.svh"
module pfr_top (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic                ce,
   input  wire logic                address_xlat_on,
   input  wire logic                intr_remap_on,
   input  wire logic                interrupt_xlat_on,
   input  wire logic                fault_valid,
   input  wire pfr_pkg::pfr_info_type fault_info,
   output logic                     fault_event,
   output logic                     irq,
   input  wire logic [11:0]         awaddr,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output logic                     wready,
   output logic [1:0]               bresp,
   output logic                     bvalid,
   input  wire logic                bready,
   input  wire logic [11:0]         araddr,
   input  wire logic                arvalid,
   output logic                     arready,
   output logic [31:0]              rdata,
   output logic [1:0]               rresp,
   output logic                     rvalid,
   input  wire logic                rready
);
   localparam int N = `PFR_NSLOT;

   // Slot decode shared by the read and write paths
   function automatic logic slot_hit(input logic [11:0] a);
      slot_hit = (a >= `PFR_OFF_SLOT) && (a < `PFR_OFF_SLOT + `PFR_SLOT_SPAN)
                 && (a[3:2] <= `PFR_SLW_VALID);
   endfunction

   logic [`PFR_IDXW-1:0]  idx_r, idx_nxt, idx_inc;
   logic [`PFR_IDXW-1:0]  first_pending_index_r, fpi_nxt;
   logic [N-1:0]          valid_r, valid_nxt, tag_eq, sw_vclr;
   pfr_pkg::pfr_info_type info_r [N];
   logic                  overflow_flag_r, ovf_nxt, sw_ovf_clr;
   logic                  event_mask_r, mask_nxt;
   logic                  event_pending_hold_r, hold_nxt;
   logic                  fault_event_r, fev_nxt;
   logic                  dup_en_r, dup_nxt;
   logic [`PFR_IRQW-1:0]  ist_r, ist_nxt, ien_r, ien_nxt, ist_set;
   logic                  pending_any, dup_hit, store, ev_req, xlat_off;
   logic                  aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
   logic [11:0]           aw_addr_r, aw_addr_nxt;
   logic [31:0]           w_data_r, w_data_nxt;
   logic                  w_lo_r, w_lo_nxt;
   logic                  bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0]            bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0]           rdata_r, rdata_nxt;
   logic                  wr_go;

   assign pending_any = |valid_r;
   assign xlat_off    = !address_xlat_on && !interrupt_xlat_on;
   assign idx_inc     = (idx_r == `PFR_IDXW'(N - 1)) ? '0 : idx_r + 1'b1;

   // Requester tag compare across every slot
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_cmp
         assign tag_eq[g] = valid_r[g] && (info_r[g].tag == fault_info.tag);
      end
   endgenerate
   assign dup_hit = dup_en_r && (|tag_eq);

   // Fault acceptance order: overflow, duplicate, slot occupancy, store
   always_comb begin
      store   = 1'b0;
      ev_req  = 1'b0;
      ist_set = '0;
      if (fault_valid) begin
         if (overflow_flag_r || dup_hit) begin
            ist_set[`PFR_IRQ_DROP] = 1'b1;
         end else if (valid_r[idx_r]) begin
            ist_set[`PFR_IRQ_OVF]  = 1'b1;
            ist_set[`PFR_IRQ_DROP] = 1'b1;
         end else begin
            store                   = 1'b1;
            ev_req                  = !pending_any;
            ist_set[`PFR_IRQ_STORE] = 1'b1;
         end
      end
   end

   // Register write decode, taken when both address and data are held
   assign wr_go = aw_full_r && w_full_r && !bvalid_r;

   always_comb begin
      sw_vclr    = '0;
      sw_ovf_clr = 1'b0;
      mask_nxt   = event_mask_r;
      dup_nxt    = dup_en_r;
      ien_nxt    = ien_r;
      ist_nxt    = ist_r;
      bresp_nxt  = bresp_r;
      if (wr_go) begin
         bresp_nxt = 2'b00;
         if (slot_hit(aw_addr_r)) begin
            if (aw_addr_r[3:2] == `PFR_SLW_VALID && w_lo_r)
               sw_vclr[aw_addr_r[`PFR_IDXW+3:4]] = w_data_r[0];
         end else begin
            unique case (aw_addr_r)
               `PFR_OFF_CAP, `PFR_OFF_IST: ;
               `PFR_OFF_STS:  sw_ovf_clr = w_lo_r && w_data_r[`PFR_STS_OVF];
               `PFR_OFF_EVC:  if (w_lo_r) mask_nxt = w_data_r[`PFR_EVC_MASK];
               `PFR_OFF_CTL:  if (w_lo_r) dup_nxt = w_data_r[`PFR_CTL_DUP];
               `PFR_OFF_ICLR: if (w_lo_r) ist_nxt = ist_r & ~w_data_r[`PFR_IRQW-1:0];
               `PFR_OFF_IEN:  if (w_lo_r) ien_nxt = w_data_r[`PFR_IRQW-1:0];
               default:       bresp_nxt = 2'b10;
            endcase
         end
      end
      // A new event beats a clear in the same cycle
      ist_nxt = ist_nxt | ist_set;
   end

   // Core state next values
   always_comb begin
      idx_nxt   = idx_r;
      fpi_nxt   = first_pending_index_r;
      valid_nxt = valid_r & ~sw_vclr;
      ovf_nxt   = overflow_flag_r & ~sw_ovf_clr;
      hold_nxt  = event_pending_hold_r;
      fev_nxt   = 1'b0;
      if (store) begin
         valid_nxt[idx_r] = 1'b1;
         idx_nxt          = idx_inc;
         if (ev_req)
            fpi_nxt = idx_r;
      end
      if (ist_set[`PFR_IRQ_OVF])
         ovf_nxt = 1'b1;
      if (xlat_off)
         idx_nxt = '0;
      // Pending faults or overflow mean software has not caught up yet
      if (ev_req && !overflow_flag_r) begin
         if (!event_mask_r) begin
            fev_nxt = 1'b1;
         end else begin
            hold_nxt = 1'b1;
         end
      end else if (event_pending_hold_r && !mask_nxt) begin
         fev_nxt  = 1'b1;
         hold_nxt = 1'b0;
      end else if (event_pending_hold_r && !pending_any && !overflow_flag_r) begin
         hold_nxt = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         idx_r                 <= '0;
         first_pending_index_r <= '0;
         valid_r               <= '0;
         overflow_flag_r       <= 1'b0;
         event_mask_r          <= `PFR_MASK_RST;
         event_pending_hold_r  <= 1'b0;
         fault_event_r         <= 1'b0;
         dup_en_r              <= `PFR_CTL_RST;
         ist_r                 <= '0;
         ien_r                 <= '0;
      end else if (ce) begin
         idx_r                 <= idx_nxt;
         first_pending_index_r <= fpi_nxt;
         valid_r               <= valid_nxt;
         overflow_flag_r       <= ovf_nxt;
         event_mask_r          <= mask_nxt;
         event_pending_hold_r  <= hold_nxt;
         fault_event_r         <= fev_nxt;
         dup_en_r              <= dup_nxt;
         ist_r                 <= ist_nxt;
         ien_r                 <= ien_nxt;
      end
   end

   // Slot payload has no reset; valid bits guard it
   always_ff @(posedge aclk) begin
      if (ce && store)
         info_r[idx_r] <= fault_info;
   end

   // Bus channel next values
   always_comb begin
      aw_full_nxt = aw_full_r;
      aw_addr_nxt = aw_addr_r;
      w_full_nxt  = w_full_r;
      w_data_nxt  = w_data_r;
      w_lo_nxt    = w_lo_r;
      bvalid_nxt  = bvalid_r;
      rvalid_nxt  = rvalid_r;
      rdata_nxt   = rdata_r;
      rresp_nxt   = rresp_r;
      if (awvalid && awready) begin
         aw_full_nxt = 1'b1;
         aw_addr_nxt = {awaddr[11:2], 2'b00};
      end
      if (wvalid && wready) begin
         w_full_nxt = 1'b1;
         w_data_nxt = wdata;
         w_lo_nxt   = wstrb[0];
      end
      if (wr_go) begin
         aw_full_nxt = 1'b0;
         w_full_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
      end
      if (bvalid_r && bready)
         bvalid_nxt = 1'b0;
      if (rvalid_r && rready)
         rvalid_nxt = 1'b0;
      if (arvalid && arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = 2'b00;
         rdata_nxt  = '0;
         if (slot_hit(araddr)) begin
            unique case (araddr[3:2])
               `PFR_SLW_ADDR: rdata_nxt = info_r[araddr[`PFR_IDXW+3:4]].addr;
               `PFR_SLW_INFO: rdata_nxt = {8'h00, info_r[araddr[`PFR_IDXW+3:4]].reason,
                                           info_r[araddr[`PFR_IDXW+3:4]].tag};
               default:       rdata_nxt[0] = valid_r[araddr[`PFR_IDXW+3:4]];
            endcase
         end else begin
            unique case ({araddr[11:2], 2'b00})
               `PFR_OFF_CAP: begin
                  rdata_nxt[7:0]          = 8'(N);
                  rdata_nxt[`PFR_CAP_DUP] = 1'b1;
               end
               `PFR_OFF_STS: begin
                  rdata_nxt[`PFR_STS_PEND] = pending_any;
                  rdata_nxt[`PFR_STS_OVF]  = overflow_flag_r;
                  rdata_nxt[`PFR_STS_FPI +: `PFR_IDXW] = first_pending_index_r;
               end
               `PFR_OFF_EVC: begin
                  rdata_nxt[`PFR_EVC_MASK] = event_mask_r;
                  rdata_nxt[`PFR_EVC_HOLD] = event_pending_hold_r;
               end
               `PFR_OFF_CTL:  rdata_nxt[`PFR_CTL_DUP] = dup_en_r;
               `PFR_OFF_IST:  rdata_nxt[`PFR_IRQW-1:0] = ist_r;
               `PFR_OFF_ICLR: ;
               `PFR_OFF_IEN:  rdata_nxt[`PFR_IRQW-1:0] = ien_r;
               default:       rresp_nxt = 2'b10;
            endcase
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         aw_addr_r <= '0;
         w_full_r  <= 1'b0;
         w_data_r  <= '0;
         w_lo_r    <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= 2'b00;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= 2'b00;
      end else if (ce) begin
         aw_full_r <= aw_full_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_full_r  <= w_full_nxt;
         w_data_r  <= w_data_nxt;
         w_lo_r    <= w_lo_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         rvalid_r  <= rvalid_nxt;
         rdata_r   <= rdata_nxt;
         rresp_r   <= rresp_nxt;
      end
   end

   // Ready terms drop with ce so nothing is taken while frozen
   assign awready     = ce && !aw_full_r && !bvalid_r;
   assign wready      = ce && !w_full_r && !bvalid_r;
   assign arready     = ce && !rvalid_r;
   assign bvalid      = bvalid_r;
   assign bresp       = bresp_r;
   assign rvalid      = rvalid_r;
   assign rdata       = rdata_r;
   assign rresp       = rresp_r;
   assign fault_event = fault_event_r;
   assign irq         = |(ist_r & ien_r);

   property p_idx_zero;
      @(posedge aclk) disable iff (!aresetn)
      ce && xlat_off |=> idx_r == '0;
   endproperty
   a_idx_zero: assert property (p_idx_zero) else $error("index not zero");

   property p_idx_adv;
      @(posedge aclk) disable iff (!aresetn)
      ce && store && !xlat_off |=> idx_r == $past(idx_inc);
   endproperty
   a_idx_adv: assert property (p_idx_adv) else $error("index not advanced");

   property p_pend;
      @(posedge aclk) disable iff (!aresetn)
      ce && store |=> pending_any && valid_r[$past(idx_r)];
   endproperty
   a_pend: assert property (p_pend) else $error("pending flag not set");

   property p_ovf_drop;
      @(posedge aclk) disable iff (!aresetn)
      ce && fault_valid && overflow_flag_r && !xlat_off |=> $stable(idx_r);
   endproperty
   a_ovf_drop: assert property (p_ovf_drop) else $error("stored in overflow");

   property p_dup;
      @(posedge aclk) disable iff (!aresetn)
      ce && fault_valid && dup_en_r && (|tag_eq) && !xlat_off |=> $stable(idx_r);
   endproperty
   a_dup: assert property (p_dup) else $error("duplicate stored");

   property p_ovf_set;
      @(posedge aclk) disable iff (!aresetn)
      ce && fault_valid && !overflow_flag_r && !dup_hit && valid_r[idx_r]
      |=> overflow_flag_r;
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow missed");

   property p_fpi;
      @(posedge aclk) disable iff (!aresetn)
      ce && store && !pending_any |=> first_pending_index_r == $past(idx_r);
   endproperty
   a_fpi: assert property (p_fpi) else $error("first index wrong");

   property p_evt;
      @(posedge aclk) disable iff (!aresetn)
      ce && ev_req && !overflow_flag_r && !event_mask_r |=> fault_event ##1 !fault_event;
   endproperty
   a_evt: assert property (p_evt) else $error("event not sent");

   property p_evt_sup;
      @(posedge aclk) disable iff (!aresetn)
      ce && pending_any && !event_pending_hold_r && !fault_event_r |=> !fault_event;
   endproperty
   a_evt_sup: assert property (p_evt_sup) else $error("event not suppressed");
endmodule
